// file: pkg/usart_pkg.sv
// Shared constants and types of the serial transceiver register block.
package usart_pkg;

   // ----------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------
   localparam logic [7:0] DATA_OFS = 8'h0c;
   localparam logic [7:0] CTRL_B_OFS = 8'h9a;
   localparam logic [7:0] STAT_A_OFS = 8'h9b;
   localparam logic [7:0] DSPACE_SHIFT = 8'h20;
   localparam logic [7:0] IO_SPACE_END = 8'h40;
   localparam logic [7:0] DATA_RST = 8'h00;

   // ----------------------------------------------------------------
   // Timing and sizes
   // ----------------------------------------------------------------
   localparam logic [4:0] OSR_NORMAL = 5'h10;
   localparam logic [4:0] OSR_DOUBLE = 5'h08;
   localparam int TX_FIFO_DEPTH = 16;
   localparam int CHAR_WIDTH = 9;

   // ----------------------------------------------------------------
   // Field layouts, most significant bit first
   // ----------------------------------------------------------------
   typedef struct packed {
      logic rx_complete_irq_enable;
      logic tx_complete_irq_enable;
      logic tx_empty_irq_enable;
      logic receiver_on;
      logic transmitter_on;
      logic char_size_high_bit;
      logic rx_ninth_bit;
      logic tx_ninth_bit;
   } ctrl_b_t;

   typedef struct packed {
      logic rx_complete_flag;
      logic tx_complete_flag;
      logic tx_buffer_empty_flag;
      logic frame_error_flag;
      logic overrun_flag;
      logic parity_error_flag;
      logic double_speed_select;
      logic multiprocessor_filter_mode;
   } status_a_t;

   localparam ctrl_b_t CTRL_B_RST = 8'h00;
   localparam status_a_t STAT_A_RST = 8'h20;

   typedef struct packed {
      logic [CHAR_WIDTH-1:0] data;
      logic frame_err;
      logic parity_err;
   } rx_entry_t;

   typedef struct packed {
      logic io_space;
      logic [7:0] addr;
      logic wr;
      logic rd;
      logic [7:0] wdata;
   } io_req_t;

   typedef struct packed {
      logic [1:0] size_low;
      logic [1:0] parity_mode;
      logic two_stop;
   } frame_cfg_t;

   typedef enum logic [2:0] {LINE_IDLE, LINE_START, LINE_DATA, LINE_PARITY, LINE_STOP} line_state_t;

endpackage

// file: rtl/usart_buffer_status_control.sv
// Data buffers, status flags and line engines of the serial transceiver.
`timescale 1ns/1ns

// ----------------------------------------------------------------
// Transmit word FIFO
// ----------------------------------------------------------------
module tx_word_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 16
) (
   input wire logic clk_i,               // system clock
   input wire logic rst_n_i,             // asynchronous reset, active low
   input wire logic ce_i,                // clock enable
   input wire logic in_valid_i,          // write request
   output logic in_ready_o,              // space available
   input wire logic [WIDTH-1:0] in_data_i, // write word
   output logic out_valid_o,             // word available
   input wire logic out_ready_i,         // read request
   output logic [WIDTH-1:0] out_data_o   // head word
);
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW-1:0] wr_ptr;
      logic [AW-1:0] rd_ptr;
      logic [AW:0] count;
   } fifo_state_t;

   fifo_state_t q;
   fifo_state_t d;
   logic push;
   logic pop;

   assign in_ready_o = q.count != (AW+1)'(DEPTH);
   assign out_valid_o = q.count != '0;
   assign out_data_o = q.mem[q.rd_ptr];
   assign push = in_valid_i && in_ready_o;
   assign pop = out_ready_i && out_valid_o;

   always_comb begin
      d = q;
      if (push) begin
         d.mem[q.wr_ptr] = in_data_i;
         d.wr_ptr = (q.wr_ptr == AW'(DEPTH - 1)) ? '0 : q.wr_ptr + 1'b1;
      end
      if (pop) begin
         d.rd_ptr = (q.rd_ptr == AW'(DEPTH - 1)) ? '0 : q.rd_ptr + 1'b1;
      end
      if (push && !pop) begin
         d.count = q.count + 1'b1;
      end else if (pop && !push) begin
         d.count = q.count - 1'b1;
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         q <= '0;
      end else if (ce_i) begin
         q <= d;
      end
   end
endmodule

// ----------------------------------------------------------------
// Transceiver top
// ----------------------------------------------------------------
module usart_buffer_status_control
   import usart_pkg::*;
#(
   parameter int TX_DEPTH = TX_FIFO_DEPTH
) (
   input wire logic REF_CLK_I,           // system clock
   input wire logic ARST_N_I,            // asynchronous reset, active low
   input wire logic CE_I,                // clock enable, freezes all state when low
   input wire io_req_t BUS_REQ_I,        // processor register access
   output logic [7:0] RDATA_O,           // read data, valid the cycle after a read
   input wire logic GLOBAL_IRQ_EN_I,     // processor global interrupt enable
   input wire logic TXC_IRQ_ACK_I,       // transmit-complete interrupt taken
   input wire logic [11:0] BAUD_DIV_I,   // baud divider value
   input wire frame_cfg_t FRAME_CFG_I,   // character size, parity, stop bits
   input wire logic RXD_I,               // serial receive pin
   output logic TXD_O,                   // serial transmit pin
   output logic TXD_OE_O,                // transmitter owns transmit pin
   output logic RXD_OWN_O,               // receiver owns receive pin
   output logic RXC_IRQ_O,               // receive-complete interrupt request
   output logic TXC_IRQ_O,               // transmit-complete interrupt request
   output logic UDRE_IRQ_O               // buffer-empty interrupt request
);

   typedef struct packed {
      ctrl_b_t ctrl;
      logic txc;
      logic u2x;
      logic mpcm;
      rx_entry_t [1:0] ent;
      logic [1:0] rx_count;
      rx_entry_t hold;
      logic hold_v;
      logic overrun;
      line_state_t tx_st;
      logic [8:0] tx_sh;
      logic [3:0] tx_bit;
      logic [3:0] tx_tick;
      logic tx_par;
      line_state_t rx_st;
      logic [8:0] rx_sh;
      logic [3:0] rx_bit;
      logic [3:0] rx_tick;
      logic rx_par;
      logic rx_pe;
      logic [11:0] baud;
      logic txd;
      logic txd_oe;
      logic [7:0] rdata;
      logic rxc_irq;
      logic txc_irq;
      logic udre_irq;
   } top_state_t;

   top_state_t q;
   top_state_t d;
   logic f_in_ready;
   logic f_out_valid;
   logic f_pop;
   logic [8:0] f_out_data;
   logic tx_run;
   logic wr_data;
   logic rd_data;

   function automatic logic hit(input io_req_t r, input logic [7:0] ofs);
      if (r.io_space) begin
         hit = (ofs < IO_SPACE_END) && (r.addr == ofs);
      end else if (ofs < IO_SPACE_END) begin
         hit = r.addr == 8'(ofs + DSPACE_SHIFT);
      end else begin
         hit = r.addr == ofs;
      end
   endfunction

   function automatic logic [3:0] char_bits(input logic hi, input logic [1:0] lo);
      if (hi) begin
         char_bits = 4'h9;
      end else begin
         char_bits = 4'(5 + lo);
      end
   endfunction

   // ----------------------------------------------------------------
   // Register decode and transmit buffer
   // ----------------------------------------------------------------
   assign wr_data = BUS_REQ_I.wr && hit(BUS_REQ_I, DATA_OFS);
   assign rd_data = BUS_REQ_I.rd && hit(BUS_REQ_I, DATA_OFS);
   assign tx_run = q.ctrl.transmitter_on || q.txd_oe;
   assign f_pop = tx_run && (q.tx_st == LINE_IDLE);

   // A write without space is refused by the FIFO and leaves queued data intact.
   tx_word_fifo #(
      .WIDTH(CHAR_WIDTH),
      .DEPTH(TX_DEPTH)
   ) u_tx_fifo (
      .clk_i(REF_CLK_I),
      .rst_n_i(ARST_N_I),
      .ce_i(CE_I),
      .in_valid_i(wr_data),
      .in_ready_o(f_in_ready),
      .in_data_i({q.ctrl.tx_ninth_bit, BUS_REQ_I.wdata}),
      .out_valid_o(f_out_valid),
      .out_ready_i(f_pop),
      .out_data_o(f_out_data)
   );

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic tick;
      logic [3:0] osr_m1;
      logic [3:0] nbits;
      logic [8:0] mask;
      logic mid;
      status_a_t st;
      ctrl_b_t cb;
      rx_entry_t e;
      tick = 1'b0;
      osr_m1 = 4'h0;
      nbits = 4'h0;
      mask = 9'h000;
      mid = 1'b0;
      st = '0;
      cb = '0;
      e = '0;
      d = q;

      tick = q.baud == 12'h000;
      d.baud = tick ? BAUD_DIV_I : q.baud - 12'h001;
      osr_m1 = 4'((q.u2x ? OSR_DOUBLE : OSR_NORMAL) - 5'h01);
      nbits = char_bits(q.ctrl.char_size_high_bit, FRAME_CFG_I.size_low);
      mask = 9'h1ff >> (4'h9 - nbits);

      // Register writes.
      if (BUS_REQ_I.wr && hit(BUS_REQ_I, CTRL_B_OFS)) begin
         d.ctrl = ctrl_b_t'(BUS_REQ_I.wdata);
      end
      if (BUS_REQ_I.wr && hit(BUS_REQ_I, STAT_A_OFS)) begin
         st = status_a_t'(BUS_REQ_I.wdata);
         d.u2x = st.double_speed_select;
         d.mpcm = st.multiprocessor_filter_mode;
         if (st.tx_complete_flag) begin
            d.txc = 1'b0;
         end
      end
      if (TXC_IRQ_ACK_I) begin
         d.txc = 1'b0;
      end

      // Register reads; frame and parity error flags describe the head entry.
      st = '0;
      st.rx_complete_flag = q.rx_count != 2'h0;
      st.tx_complete_flag = q.txc;
      st.tx_buffer_empty_flag = f_in_ready;
      st.frame_error_flag = st.rx_complete_flag && q.ent[0].frame_err;
      st.overrun_flag = q.overrun;
      st.parity_error_flag = st.rx_complete_flag && q.ent[0].parity_err;
      st.double_speed_select = q.u2x;
      st.multiprocessor_filter_mode = q.mpcm;
      cb = q.ctrl;
      cb.rx_ninth_bit = q.ent[0].data[8];
      if (rd_data) begin
         d.rdata = q.ent[0].data[7:0];
      end else if (BUS_REQ_I.rd && hit(BUS_REQ_I, STAT_A_OFS)) begin
         d.rdata = st;
      end else if (BUS_REQ_I.rd && hit(BUS_REQ_I, CTRL_B_OFS)) begin
         d.rdata = cb;
      end

      // Receive FIFO pop; a waiting shifter character refills the freed slot.
      if (rd_data) begin
         d.overrun = 1'b0;
         if (q.rx_count != 2'h0) begin
            d.ent[0] = q.ent[1];
            d.rx_count = q.rx_count - 2'h1;
            if (q.hold_v) begin
               d.ent[d.rx_count[0]] = q.hold;
               d.rx_count = d.rx_count + 2'h1;
               d.hold_v = 1'b0;
            end
         end
      end

      // Receiver.
      if (!q.ctrl.receiver_on) begin
         d.rx_count = 2'h0;
         d.hold_v = 1'b0;
         d.overrun = 1'b0;
         d.rx_st = LINE_IDLE;
      end else if (q.rx_st == LINE_IDLE) begin
         if (!RXD_I) begin
            d.rx_st = LINE_START;
            d.rx_tick = 4'h0;
            d.rx_bit = 4'h0;
            d.rx_sh = 9'h000;
            d.rx_par = 1'b0;
            d.rx_pe = 1'b0;
            if (q.rx_count == 2'h2 && q.hold_v) begin
               d.overrun = 1'b1;
            end
         end
      end else if (tick) begin
         d.rx_tick = q.rx_tick + 4'h1;
         mid = q.rx_tick == (osr_m1 >> 1);
         if (mid) begin
            case (q.rx_st)
               LINE_START: begin
                  if (RXD_I) begin
                     d.rx_st = LINE_IDLE;
                  end
               end
               LINE_DATA: begin
                  d.rx_sh[q.rx_bit] = RXD_I;
                  d.rx_par = q.rx_par ^ RXD_I;
               end
               LINE_PARITY: begin
                  d.rx_pe = RXD_I != (q.rx_par ^ FRAME_CFG_I.parity_mode[0]);
               end
               default: begin
                  d.rx_st = LINE_IDLE;
                  e.data = q.rx_sh;
                  e.frame_err = !RXD_I;
                  e.parity_err = q.rx_pe;
                  if (!q.mpcm || nbits != 4'h9 || q.rx_sh[8]) begin
                     if (d.rx_count != 2'h2) begin
                        d.ent[d.rx_count[0]] = e;
                        d.rx_count = d.rx_count + 2'h1;
                     end else if (!d.hold_v) begin
                        d.hold = e;
                        d.hold_v = 1'b1;
                     end
                  end
               end
            endcase
         end else if (q.rx_tick == osr_m1) begin
            d.rx_tick = 4'h0;
            case (q.rx_st)
               LINE_START: begin
                  d.rx_st = LINE_DATA;
               end
               LINE_DATA: begin
                  if (q.rx_bit == nbits - 4'h1) begin
                     d.rx_st = FRAME_CFG_I.parity_mode[1] ? LINE_PARITY : LINE_STOP;
                  end else begin
                     d.rx_bit = q.rx_bit + 4'h1;
                  end
               end
               default: begin
                  d.rx_st = LINE_STOP;
               end
            endcase
         end
      end

      // Transmitter.
      if (q.tx_st == LINE_IDLE) begin
         if (f_pop && f_out_valid) begin
            d.tx_st = LINE_START;
            d.tx_sh = f_out_data & mask;
            d.tx_par = (^(f_out_data & mask)) ^ FRAME_CFG_I.parity_mode[0];
            d.tx_tick = 4'h0;
            d.tx_bit = 4'h0;
         end
      end else if (tick) begin
         d.tx_tick = q.tx_tick + 4'h1;
         if (q.tx_tick == osr_m1) begin
            d.tx_tick = 4'h0;
            case (q.tx_st)
               LINE_START: begin
                  d.tx_st = LINE_DATA;
               end
               LINE_DATA: begin
                  if (q.tx_bit == nbits - 4'h1) begin
                     d.tx_bit = 4'h0;
                     d.tx_st = FRAME_CFG_I.parity_mode[1] ? LINE_PARITY : LINE_STOP;
                  end else begin
                     d.tx_bit = q.tx_bit + 4'h1;
                  end
               end
               LINE_PARITY: begin
                  d.tx_st = LINE_STOP;
               end
               default: begin
                  if (FRAME_CFG_I.two_stop && q.tx_bit == 4'h0) begin
                     d.tx_bit = 4'h1;
                  end else begin
                     d.tx_st = LINE_IDLE;
                     if (!f_out_valid) begin
                        d.txc = 1'b1;
                     end
                  end
               end
            endcase
         end
      end
      case (d.tx_st)
         LINE_START: d.txd = 1'b0;
         LINE_DATA: d.txd = d.tx_sh[d.tx_bit];
         LINE_PARITY: d.txd = d.tx_par;
         default: d.txd = 1'b1;
      endcase
      d.txd_oe = q.ctrl.transmitter_on || (q.txd_oe && (d.tx_st != LINE_IDLE || f_out_valid));

      // Interrupt requests.
      d.rxc_irq = q.ctrl.rx_complete_irq_enable && GLOBAL_IRQ_EN_I && (q.rx_count != 2'h0);
      d.txc_irq = q.ctrl.tx_complete_irq_enable && GLOBAL_IRQ_EN_I && q.txc;
      d.udre_irq = q.ctrl.tx_empty_irq_enable && GLOBAL_IRQ_EN_I && f_in_ready;
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         q <= '0;
         q.ctrl <= CTRL_B_RST;
         q.u2x <= STAT_A_RST.double_speed_select;
         q.mpcm <= STAT_A_RST.multiprocessor_filter_mode;
         q.txd <= 1'b1;
         q.rdata <= DATA_RST;
      end else if (CE_I) begin
         q <= d;
      end
   end

   assign RDATA_O = q.rdata;
   assign TXD_O = q.txd;
   assign TXD_OE_O = q.txd_oe;
   assign RXD_OWN_O = q.ctrl.receiver_on;
   assign RXC_IRQ_O = q.rxc_irq;
   assign TXC_IRQ_O = q.txc_irq;
   assign UDRE_IRQ_O = q.udre_irq;
endmodule

// file: testbench/usart_assertions.sv
// Concurrent checks on the ports of the serial transceiver block.
`timescale 1ns/1ns
module usart_chk
   import usart_pkg::*;
(
   input wire logic REF_CLK_I,       // system clock
   input wire logic ARST_N_I,        // reset, active low
   input wire logic CE_I,            // clock enable
   input wire io_req_t BUS_REQ_I,    // register access
   input wire logic [7:0] RDATA_O,   // read data
   input wire logic GLOBAL_IRQ_EN_I, // global interrupt enable
   input wire logic TXD_O,           // serial out
   input wire logic TXD_OE_O,        // transmit pin owned
   input wire logic RXD_OWN_O,       // receive pin owned
   input wire logic RXC_IRQ_O,       // receive interrupt
   input wire logic TXC_IRQ_O,       // transmit interrupt
   input wire logic UDRE_IRQ_O       // empty interrupt
);
   logic hit;
   logic wrb;
   logic own_q;
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (!ARST_N_I);
   assign hit = BUS_REQ_I.io_space ? (BUS_REQ_I.addr == DATA_OFS) :
                (BUS_REQ_I.addr inside {DATA_OFS + DSPACE_SHIFT, CTRL_B_OFS, STAT_A_OFS});
   assign wrb = CE_I && BUS_REQ_I.wr && !BUS_REQ_I.io_space && BUS_REQ_I.addr == CTRL_B_OFS;
   // Last receiver enable written, to compare the pin ownership against.
   always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         own_q <= 1'b0;
      end else if (wrb) begin
         own_q <= BUS_REQ_I.wdata[4];
      end
   end
   rx_irq_gate_a: assert property (RXC_IRQ_O |-> $past(GLOBAL_IRQ_EN_I))
      else $error("receive interrupt without global enable");
   tx_irq_gate_a: assert property (TXC_IRQ_O |-> $past(GLOBAL_IRQ_EN_I))
      else $error("transmit interrupt without global enable");
   empty_irq_gate_a: assert property (UDRE_IRQ_O |-> $past(GLOBAL_IRQ_EN_I))
      else $error("empty interrupt without global enable");
   unmapped_read_a: assert property (CE_I && BUS_REQ_I.rd && !hit |=> $stable(RDATA_O))
      else $error("unmapped read changed read data");
   rx_pin_own_a: assert property (wrb |-> ##2 (RXD_OWN_O == own_q))
      else $error("receive pin ownership does not follow enable");
   rx_flush_a: assert property (!RXD_OWN_O |-> ##2 !RXC_IRQ_O)
      else $error("receive interrupt while receiver off");
   idle_high_a: assert property (!TXD_OE_O |-> TXD_O)
      else $error("released line not high");
   start_len_a: assert property ($fell(TXD_O) |-> !TXD_O [*8])
      else $error("line low shorter than a bit");
   tx_release_a: assert property ($fell(TXD_OE_O) |-> TXD_O && $past(TXD_O, 4))
      else $error("transmit pin released inside a frame");
endmodule

// file: testbench/serial_peer.sv
// Remote serial transceiver model on the line.
`timescale 1ns/1ns
module serial_peer (
   input wire logic clk_i, // system clock
   input wire logic txd_i, // line from the block
   output logic rxd_o      // line to the block
);
   int bit_clks = 16;
   int got = 0;
   logic [7:0] last = 8'h00;
   logic [7:0] sh;
   initial rxd_o = 1'b1;
   task automatic put(input logic b);
      rxd_o <= b;
      repeat (bit_clks) @(posedge clk_i);
   endtask
   // Sends start, data, optional parity, stop, then one idle bit.
   task automatic send(input logic [8:0] d, input int n, input logic par, input logic bad, input logic stop);
      logic p;
      p = bad;
      @(posedge clk_i);
      put(1'b0);
      for (int i = 0; i < n; i++) begin
         put(d[i]);
         p = p ^ d[i];
      end
      if (par) begin
         put(p);
      end
      put(stop);
      put(1'b1);
   endtask
   always begin
      @(posedge clk_i);
      if (txd_i === 1'b0) begin
         repeat (bit_clks / 2) @(posedge clk_i);
         for (int i = 0; i < 8; i++) begin
            repeat (bit_clks) @(posedge clk_i);
            sh[i] = txd_i;
         end
         repeat (bit_clks) @(posedge clk_i);
         last = sh;
         got++;
      end
   end
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the serial transceiver register block.
`timescale 1ns/1ns
bind usart_buffer_status_control usart_chk chk_i (.REF_CLK_I(REF_CLK_I), .ARST_N_I(ARST_N_I), .CE_I(CE_I),
   .BUS_REQ_I(BUS_REQ_I), .RDATA_O(RDATA_O), .GLOBAL_IRQ_EN_I(GLOBAL_IRQ_EN_I), .TXD_O(TXD_O),
   .TXD_OE_O(TXD_OE_O), .RXD_OWN_O(RXD_OWN_O), .RXC_IRQ_O(RXC_IRQ_O), .TXC_IRQ_O(TXC_IRQ_O),
   .UDRE_IRQ_O(UDRE_IRQ_O));
module testbench import usart_pkg::*;;
   logic clk = 1'b0;
   logic arst_n = 1'b0;
   logic ce = 1'b1;
   logic gie = 1'b1;
   logic ack = 1'b0;
   logic rxd;
   logic [7:0] rdata;
   logic txd, txd_oe, rx_own, rxc_irq, txc_irq, udre_irq;
   io_req_t req = '0;
   frame_cfg_t cfg = 5'h18;
   int mismatches = 0;
   int compares = 0;
   int base;
   logic [7:0] v;
   always #10 clk = ~clk;
   usart_buffer_status_control dut (.REF_CLK_I(clk), .ARST_N_I(arst_n), .CE_I(ce), .BUS_REQ_I(req),
      .RDATA_O(rdata), .GLOBAL_IRQ_EN_I(gie), .TXC_IRQ_ACK_I(ack), .BAUD_DIV_I(12'h000),
      .FRAME_CFG_I(cfg), .RXD_I(rxd), .TXD_O(txd), .TXD_OE_O(txd_oe), .RXD_OWN_O(rx_own),
      .RXC_IRQ_O(rxc_irq), .TXC_IRQ_O(txc_irq), .UDRE_IRQ_O(udre_irq));
   serial_peer peer (.clk_i(clk), .txd_i(txd), .rxd_o(rxd));
   task automatic chk(input string n, input logic [7:0] s, input logic [7:0] e);
      compares++;
      if (s !== e) begin
         mismatches++;
         $display("[ERR] %s expected %h seen %h", n, e, s);
      end
   endtask
   // One bus cycle; read data is taken once it has settled a cycle later.
   task automatic acc(input logic io, input logic [7:0] a, input logic w, input logic [7:0] d);
      @(posedge clk);
      req <= '{io, a, w, !w, d};
      @(posedge clk);
      req <= '0;
      @(posedge clk);
      v = rdata;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      acc(a == DATA_OFS, a, 1'b1, d);
   endtask
   // Plain reads only; no read-modify-write on the data location.
   task automatic rd(input logic [7:0] a, input string n, input logic [7:0] e);
      acc(a == DATA_OFS, a, 1'b0, 8'h00);
      chk(n, v, e);
   endtask
   task automatic close_out();
      $display("mismatches %0d compares %0d", mismatches, compares);
      if (mismatches == 0 && compares > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask
   task automatic wait_got(input int n);
      for (int i = 0; i < 5000 && peer.got < n; i++) @(posedge clk);
      if (peer.got < n) begin
         mismatches++;
         $display("[ERR] peer frames expected %0d seen %0d", n, peer.got);
         close_out();
      end
   endtask
   initial begin
      repeat (5) @(posedge clk);
      arst_n <= 1'b1;
      rd(STAT_A_OFS, "stat", STAT_A_RST);
      rd(CTRL_B_OFS, "ctrl", CTRL_B_RST);
      rd(DATA_OFS, "data", DATA_RST);
      wr(CTRL_B_OFS, 8'h98);
      acc(1'b1, CTRL_B_OFS, 1'b1, 8'hff);
      rd(CTRL_B_OFS, "ctrl", 8'h98);
      acc(1'b1, STAT_A_OFS, 1'b0, 8'h00);
      chk("unmapped", v, 8'h98);
      ce <= 1'b0;
      wr(CTRL_B_OFS, 8'h00);
      ce <= 1'b1;
      rd(CTRL_B_OFS, "ctrl_frozen", 8'h98);
      chk("own", {7'h00, rx_own}, 8'h01);
      peer.send(9'h03c, 8, 1'b0, 1'b0, 1'b1);
      chk("rxc_irq", {7'h00, rxc_irq}, 8'h01);
      peer.send(9'h081, 8, 1'b0, 1'b0, 1'b0);
      rd(STAT_A_OFS, "stat", 8'ha0);
      rd(8'h2c, "data", 8'h3c);
      rd(STAT_A_OFS, "stat", 8'hb0);
      rd(DATA_OFS, "data", 8'h81);
      wr(CTRL_B_OFS, 8'h08);
      rd(STAT_A_OFS, "stat", 8'h20);
      wr(CTRL_B_OFS, 8'h98);
      for (int i = 0; i < 4; i++) peer.send(9'(9'h011 + i), 8, 1'b0, 1'b0, 1'b1);
      rd(STAT_A_OFS, "stat", 8'ha8);
      rd(DATA_OFS, "data", 8'h11);
      rd(STAT_A_OFS, "stat", 8'ha0);
      wr(CTRL_B_OFS, 8'h08);
      rd(STAT_A_OFS, "stat", 8'h20);
      wr(CTRL_B_OFS, 8'h98);
      @(posedge clk);
      cfg.parity_mode <= 2'h2;
      peer.send(9'h007, 8, 1'b1, 1'b1, 1'b1);
      rd(STAT_A_OFS, "stat", 8'ha4);
      rd(DATA_OFS, "data", 8'h07);
      cfg <= 5'h00;
      peer.send(9'h1ff, 5, 1'b0, 1'b0, 1'b1);
      rd(DATA_OFS, "data", 8'h1f);
      cfg <= 5'h18;
      wr(STAT_A_OFS, 8'h02);
      peer.bit_clks = 8;
      peer.send(9'h05a, 8, 1'b0, 1'b0, 1'b1);
      rd(DATA_OFS, "data", 8'h5a);
      rd(STAT_A_OFS, "stat", 8'h22);
      peer.bit_clks = 16;
      wr(STAT_A_OFS, 8'h00);
      wr(CTRL_B_OFS, 8'h9c);
      wr(STAT_A_OFS, 8'h01);
      peer.send(9'h055, 9, 1'b0, 1'b0, 1'b1);
      rd(STAT_A_OFS, "stat", 8'h21);
      peer.send(9'h1aa, 9, 1'b0, 1'b0, 1'b1);
      rd(CTRL_B_OFS, "ctrl", 8'h9e);
      rd(DATA_OFS, "data", 8'haa);
      wr(STAT_A_OFS, 8'h00);
      wr(CTRL_B_OFS, 8'h58);
      base = peer.got;
      wr(DATA_OFS, 8'ha5);
      wait_got(base + 1);
      chk("line", peer.last, 8'ha5);
      repeat (24) @(posedge clk);
      rd(STAT_A_OFS, "stat", 8'h60);
      chk("txc_irq", {7'h00, txc_irq}, 8'h01);
      ack <= 1'b1;
      @(posedge clk);
      ack <= 1'b0;
      rd(STAT_A_OFS, "stat", 8'h20);
      wr(8'h2c, 8'h3f);
      wait_got(base + 2);
      chk("line", peer.last, 8'h3f);
      repeat (24) @(posedge clk);
      wr(STAT_A_OFS, 8'h40);
      rd(STAT_A_OFS, "stat", 8'h20);
      wr(CTRL_B_OFS, 8'h38);
      repeat (3) @(posedge clk);
      chk("udre_irq", {7'h00, udre_irq}, 8'h01);
      gie <= 1'b0;
      repeat (3) @(posedge clk);
      chk("udre_irq", {7'h00, udre_irq}, 8'h00);
      gie <= 1'b1;
      wr(CTRL_B_OFS, 8'h18);
      base = peer.got;
      for (int i = 0; i < 20; i++) wr(DATA_OFS, 8'(8'h40 + i));
      rd(STAT_A_OFS, "stat", 8'h00);
      wr(CTRL_B_OFS, 8'h10);
      chk("txd_oe", {7'h00, txd_oe}, 8'h01);
      wait_got(base + 17);
      repeat (40) @(posedge clk);
      chk("frames", 8'(peer.got - base), 8'h11);
      chk("line", peer.last, 8'h50);
      chk("txd_oe", {7'h00, txd_oe}, 8'h00);
      close_out();
   end
endmodule
